//--- disc_seek_params.svh
// Constants for the seek select interface: field positions, widths and timing counts
`ifndef DISC_SEEK_PARAMS_SVH
`define DISC_SEEK_PARAMS_SVH
`define CORE_PERIOD_NS 10
`define LINK_PERIOD_NS 64
`define LEAD_NS        250
`define LEAD_CYC       ((`LEAD_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)
`define ANS_SHORT_NS   20000
`define ANS_SHORT_CYC  (`ANS_SHORT_NS / `CORE_PERIOD_NS)
`define ANS_LONG_NS    40000
`define ANS_LONG_CYC   (`ANS_LONG_NS / `CORE_PERIOD_NS)
`define TMR_W          12
`define ADDR_W         26
`define IDX_W          5
`define NCH            16
`define F_ONS          0
`define F_FH           1
`define F_REC_LO       2
`define REC_W          8
`define F_POS_LO       10
`define POS_W          6
`define F_DISC_LO      16
`define DISC_W         5
`define F_CH_LO        21
`define PAR_NARROW     23
`define PAR_WIDE       25
`define FH_POS_MAX     6'h0B
`define TGT_W          12
`endif

//--- disc_seek_pkg.sv
// State types for the seek select interface
package disc_seek_pkg;
	typedef enum logic [1:0] {
		LK_IDLE  = 2'b00,
		LK_LEAD  = 2'b01,
		LK_SHIFT = 2'b10,
		LK_HOLD  = 2'b11
	} link_st_t;
	typedef enum logic [1:0] {
		CS_IDLE  = 2'b00,
		CS_TIME  = 2'b01,
		CS_BUSYW = 2'b10
	} core_st_t;
endpackage : disc_seek_pkg

//--- disc_seek_select.sv
// Seek select interface: serial address intake on the link clock, answer logic on the core clock
`timescale 1ns/1ns
`include "disc_seek_params.svh"

module disc_seek_select
	import disc_seek_pkg::*;
(
	// Clocks and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   link_clk,
	// Configuration straps
	input  wire logic                   wide_chan_cfg,
	input  wire logic                   fh_fitted,
	// Host link
	input  wire logic                   select_in,
	input  wire logic                   wdata_in,
	output logic                        bit_strobe,
	input  wire logic                   end_in,
	// Answer levels to host
	output logic                        seek_ok,
	output logic                        busy,
	output logic                        seek_err,
	output logic                        wrong_cmd,
	output logic                        held_peer,
	output logic                        settled,
	// Drive side status
	input  wire logic [`NCH-1:0]        area_conflict,
	input  wire logic                   fh_other,
	input  wire logic [`NCH-1:0]        peer_attached,
	input  wire logic [`NCH-1:0]        pos_power,
	input  wire logic [`NCH-1:0]        hdr_settled,
	input  wire logic [`NCH-1:0]        ch_clear,
	// Drive side control
	output logic [`NCH-1:0]             pos_enable,
	output logic [3:0]                  conn_ch,
	output logic                        ons_bit,
	output logic                        fh_sel,
	output logic [`REC_W-1:0]           rec_sel,
	output logic [`POS_W-1:0]           pos_sel,
	output logic [`DISC_W-1:0]          disc_sel
);

	// Link domain synchronisers; reset is carried over too
	logic lrst_s1, lrst_s2, sel_s1, sel_s2, sel_s3, wd_s1, wd_s2;
	logic ack_s1, ack_s2, lwide_s1, lwide_s2, lfh_s1, lfh_s2;
	logic ack_tgl_r;
	always_ff @(posedge link_clk) begin
		lrst_s1  <= rst;
		lrst_s2  <= lrst_s1;
		sel_s1   <= select_in;
		sel_s2   <= sel_s1;
		sel_s3   <= sel_s2;
		wd_s1    <= wdata_in;
		wd_s2    <= wd_s1;
		ack_s1   <= ack_tgl_r;
		ack_s2   <= ack_s1;
		lwide_s1 <= wide_chan_cfg;
		lwide_s2 <= lwide_s1;
		lfh_s1   <= fh_fitted;
		lfh_s2   <= lfh_s1;
	end

	// Link domain state
	link_st_t           lk_r, lk_nxt;
	logic [2:0]         lcnt_r, lcnt_nxt;
	logic [`IDX_W-1:0]  idx_r, idx_nxt, last_idx;
	logic [`ADDR_W-1:0] addr_r, addr_nxt;
	logic               pend_r, pend_nxt, ack_seen_r, ack_seen_nxt;
	logic               req_tgl_r, req_tgl_nxt, sel_tgl_r, sel_tgl_nxt;
	logic               wrg_tgl_r, wrg_tgl_nxt, strobe_nxt, sel_edge;

	// Intake sequence; address word is frozen from the last bit until the core acknowledges the request
	always_comb begin
		lk_nxt       = lk_r;
		lcnt_nxt     = lcnt_r;
		idx_nxt      = idx_r;
		addr_nxt     = addr_r;
		pend_nxt     = pend_r;
		ack_seen_nxt = ack_seen_r;
		req_tgl_nxt  = req_tgl_r;
		sel_tgl_nxt  = sel_tgl_r;
		wrg_tgl_nxt  = wrg_tgl_r;
		strobe_nxt   = 1'b0;
		sel_edge     = sel_s2 & ~sel_s3;
		last_idx     = lwide_s2 ? `IDX_W'(`PAR_WIDE) : `IDX_W'(`PAR_NARROW);
		if (pend_r && (ack_s2 != ack_seen_r)) begin
			pend_nxt     = 1'b0;
			ack_seen_nxt = ack_s2;
		end
		unique case (lk_r)
			LK_IDLE: begin
			end
			LK_LEAD: begin
				if (lcnt_r == 3'(`LEAD_CYC - 1)) begin
					lk_nxt   = LK_SHIFT;
					lcnt_nxt = 3'h0;
				end else begin
					lcnt_nxt = lcnt_r + 3'h1;
				end
			end
			LK_SHIFT: begin
				strobe_nxt = (lcnt_r == 3'h0);
				if (lcnt_r == 3'h3) begin
					addr_nxt[idx_r] = wd_s2;
					lcnt_nxt        = 3'h0;
					if (idx_r == last_idx) begin
						lk_nxt      = LK_HOLD;
						req_tgl_nxt = ~req_tgl_r;
					end else if (idx_r == `IDX_W'(`F_ONS) && !lfh_s2) begin
						idx_nxt = `IDX_W'(`F_REC_LO);
					end else begin
						idx_nxt = idx_r + `IDX_W'(1);
					end
				end else begin
					lcnt_nxt = lcnt_r + 3'h1;
				end
			end
			LK_HOLD: begin
				if (!pend_nxt) begin
					lk_nxt = LK_IDLE;
				end
			end
		endcase
		// Early select is refused here; the pending address stays intact
		if (sel_edge) begin
			if (pend_nxt) begin
				wrg_tgl_nxt = ~wrg_tgl_r;
			end else begin
				pend_nxt    = 1'b1;
				sel_tgl_nxt = ~sel_tgl_r;
				lk_nxt      = LK_LEAD;
				lcnt_nxt    = 3'h0;
				idx_nxt     = `IDX_W'(`F_ONS);
				addr_nxt    = '0;
			end
		end
	end

	// Link domain registers
	always_ff @(posedge link_clk) begin
		if (lrst_s2) begin
			lk_r       <= LK_IDLE;
			lcnt_r     <= 3'h0;
			idx_r      <= '0;
			addr_r     <= '0;
			pend_r     <= 1'b0;
			ack_seen_r <= 1'b0;
			req_tgl_r  <= 1'b0;
			sel_tgl_r  <= 1'b0;
			wrg_tgl_r  <= 1'b0;
			bit_strobe <= 1'b0;
		end else begin
			lk_r       <= lk_nxt;
			lcnt_r     <= lcnt_nxt;
			idx_r      <= idx_nxt;
			addr_r     <= addr_nxt;
			pend_r     <= pend_nxt;
			ack_seen_r <= ack_seen_nxt;
			req_tgl_r  <= req_tgl_nxt;
			sel_tgl_r  <= sel_tgl_nxt;
			wrg_tgl_r  <= wrg_tgl_nxt;
			bit_strobe <= strobe_nxt;
		end
	end

	// Core domain synchronisers for link events and drive status
	logic req_s1, req_s2, req_s3, csel_s1, csel_s2, csel_s3;
	logic wrg_s1, wrg_s2, wrg_s3, end_s1, end_s2, end_s3;
	logic cwide_s1, cwide_s2, fho_s1, fho_s2;
	logic [`NCH-1:0] cfl_s1, cfl_s2, peer_s1, peer_s2, pwr_s1, pwr_s2;
	logic [`NCH-1:0] hdr_s1, hdr_s2, clr_s1, clr_s2;
	always_ff @(posedge core_clk) begin
		req_s1   <= req_tgl_r;
		req_s2   <= req_s1;
		req_s3   <= req_s2;
		csel_s1  <= sel_tgl_r;
		csel_s2  <= csel_s1;
		csel_s3  <= csel_s2;
		wrg_s1   <= wrg_tgl_r;
		wrg_s2   <= wrg_s1;
		wrg_s3   <= wrg_s2;
		end_s1   <= end_in;
		end_s2   <= end_s1;
		end_s3   <= end_s2;
		cwide_s1 <= wide_chan_cfg;
		cwide_s2 <= cwide_s1;
		fho_s1   <= fh_other;
		fho_s2   <= fho_s1;
		cfl_s1   <= area_conflict;
		cfl_s2   <= cfl_s1;
		peer_s1  <= peer_attached;
		peer_s2  <= peer_s1;
		pwr_s1   <= pos_power;
		pwr_s2   <= pwr_s1;
		hdr_s1   <= hdr_settled;
		hdr_s2   <= hdr_s1;
		clr_s1   <= ch_clear;
		clr_s2   <= clr_s1;
	end

	// Address decode; addr_r is stable whenever the request toggle is seen
	logic              req_ev, sel_ev, wrg_ev, end_ev, par_ok, fh_d, match, bad_fh;
	logic [3:0]        ch_d;
	logic [`POS_W-1:0] pos_d;
	logic [`TGT_W-1:0] tgt_d;
	always_comb begin
		req_ev = req_s2 ^ req_s3;
		sel_ev = csel_s2 ^ csel_s3;
		wrg_ev = wrg_s2 ^ wrg_s3;
		end_ev = end_s2 & ~end_s3;
		par_ok = ^addr_r;
		fh_d   = addr_r[`F_FH];
		pos_d  = addr_r[`F_POS_LO +: `POS_W];
		ch_d   = cwide_s2 ? addr_r[`F_CH_LO +: 4] : {2'b00, addr_r[`F_CH_LO +: 2]};
		tgt_d  = {fh_d, addr_r[`F_DISC_LO +: `DISC_W], pos_d};
		bad_fh = fh_d && (pos_d > `FH_POS_MAX);
	end

	// Core domain state; per-channel target and confirmed memory
	core_st_t          cs_r, cs_nxt;
	logic [`TMR_W-1:0] tmr_r, tmr_nxt;
	logic [`TGT_W-1:0] tgt_r [`NCH];
	logic [`TGT_W-1:0] tgt_nxt [`NCH];
	logic [`NCH-1:0]   cfm_r, cfm_nxt, pos_en_nxt;
	logic              cfmg_r, cfmg_nxt, fast_r, fast_nxt, ack_tgl_nxt;
	logic              ok_nxt, busy_nxt, err_nxt, wrong_nxt, held_nxt, set_nxt;
	logic [3:0]        conn_nxt;
	logic              ons_nxt, fh_nxt;
	logic [`REC_W-1:0] rec_nxt;
	logic [`POS_W-1:0] pos_nxt;
	logic [`DISC_W-1:0] disc_nxt;
	assign match = (tgt_r[ch_d] == tgt_d);

	// Answer sequence and confirmation tracking
	always_comb begin
		cs_nxt      = cs_r;
		tmr_nxt     = tmr_r;
		tgt_nxt     = tgt_r;
		cfm_nxt     = cfm_r;
		pos_en_nxt  = pos_enable;
		cfmg_nxt    = cfmg_r;
		fast_nxt    = fast_r;
		ack_tgl_nxt = ack_tgl_r;
		ok_nxt      = seek_ok;
		busy_nxt    = busy;
		err_nxt     = seek_err;
		wrong_nxt   = wrong_cmd;
		held_nxt    = held_peer;
		set_nxt     = settled;
		conn_nxt    = conn_ch;
		ons_nxt     = ons_bit;
		fh_nxt      = fh_sel;
		rec_nxt     = rec_sel;
		pos_nxt     = pos_sel;
		disc_nxt    = disc_sel;
		// Channel clear drops stored state; a settle below still wins
		for (int c = 0; c < `NCH; c++) begin
			if (clr_s2[c]) begin
				cfm_nxt[c]    = 1'b0;
				pos_en_nxt[c] = 1'b0;
			end
		end
		// End drops settled; a settle landing in the same cycle wins
		if (end_ev) begin
			set_nxt = 1'b0;
		end
		// Only the connected channel is confirmed
		if (cfmg_r && hdr_s2[conn_ch]) begin
			set_nxt          = 1'b1;
			cfm_nxt[conn_ch] = 1'b1;
			cfmg_nxt         = 1'b0;
		end
		// Accepted select clears every level and aborts confirmation
		if (sel_ev) begin
			{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h0;
			wrong_nxt = 1'b0;
			set_nxt   = 1'b0;
			cfmg_nxt  = 1'b0;
			if (cs_r == CS_BUSYW) begin
				cs_nxt = CS_IDLE;
			end
		end
		// Out-of-order select: error level, first request keeps running
		if (wrg_ev) begin
			{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h2;
			wrong_nxt = 1'b1;
		end
		unique case (cs_r)
			CS_IDLE: begin
				if (req_ev) begin
					conn_nxt = ch_d;
					ons_nxt  = addr_r[`F_ONS];
					fh_nxt   = fh_d;
					rec_nxt  = addr_r[`F_REC_LO +: `REC_W];
					pos_nxt  = pos_d;
					disc_nxt = addr_r[`F_DISC_LO +: `DISC_W];
					cfmg_nxt = 1'b0;
					fast_nxt = 1'b0;
					if (!par_ok || bad_fh) begin
						{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h2;
						ack_tgl_nxt = ~ack_tgl_r;
					end else if (cwide_s2 && peer_s2[ch_d]) begin
						{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h1;
						ack_tgl_nxt = ~ack_tgl_r;
					end else begin
						if (!match) begin
							cfm_nxt[ch_d] = 1'b0;
						end
						tgt_nxt[ch_d] = tgt_d;
						if (cfl_s2[ch_d] || (fh_d && fho_s2)) begin
							{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h4;
							ack_tgl_nxt = ~ack_tgl_r;
							cs_nxt      = CS_BUSYW;
						end else begin
							fast_nxt = match && cfm_r[ch_d];
							cs_nxt   = CS_TIME;
							if ((match && pos_enable[ch_d]) || !pwr_s2[ch_d] || fh_d) begin
								tmr_nxt = `TMR_W'(`ANS_SHORT_CYC - 1);
							end else begin
								tmr_nxt = `TMR_W'(`ANS_LONG_CYC - 1);
							end
						end
					end
				end
			end
			CS_TIME: begin
				if (tmr_r == '0) begin
					{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h8;
					set_nxt             = fast_r;
					cfmg_nxt            = !fast_r;
					pos_en_nxt[conn_ch] = 1'b1;
					ack_tgl_nxt         = ~ack_tgl_r;
					cs_nxt              = CS_IDLE;
				end else begin
					tmr_nxt = tmr_r - `TMR_W'(1);
				end
			end
			CS_BUSYW: begin
				// Held address goes ahead once released; a new select drops it
				if (!sel_ev && !cfl_s2[conn_ch] && !(fh_sel && fho_s2)) begin
					{ok_nxt, busy_nxt, err_nxt, held_nxt} = 4'h8;
					pos_en_nxt[conn_ch] = 1'b1;
					cfmg_nxt            = 1'b1;
					cs_nxt              = CS_IDLE;
				end
			end
			default: begin
				cs_nxt = CS_IDLE;
			end
		endcase
	end

	// Core domain registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cs_r       <= CS_IDLE;
			tmr_r      <= '0;
			tgt_r      <= '{default: '0};
			cfm_r      <= '0;
			pos_enable <= '0;
			cfmg_r     <= 1'b0;
			fast_r     <= 1'b0;
			ack_tgl_r  <= 1'b0;
			seek_ok    <= 1'b0;
			busy       <= 1'b0;
			seek_err   <= 1'b0;
			wrong_cmd  <= 1'b0;
			held_peer  <= 1'b0;
			settled    <= 1'b0;
			conn_ch    <= 4'h0;
			ons_bit    <= 1'b0;
			fh_sel     <= 1'b0;
			rec_sel    <= '0;
			pos_sel    <= '0;
			disc_sel   <= '0;
		end else begin
			cs_r       <= cs_nxt;
			tmr_r      <= tmr_nxt;
			tgt_r      <= tgt_nxt;
			cfm_r      <= cfm_nxt;
			pos_enable <= pos_en_nxt;
			cfmg_r     <= cfmg_nxt;
			fast_r     <= fast_nxt;
			ack_tgl_r  <= ack_tgl_nxt;
			seek_ok    <= ok_nxt;
			busy       <= busy_nxt;
			seek_err   <= err_nxt;
			wrong_cmd  <= wrong_nxt;
			held_peer  <= held_nxt;
			settled    <= set_nxt;
			conn_ch    <= conn_nxt;
			ons_bit    <= ons_nxt;
			fh_sel     <= fh_nxt;
			rec_sel    <= rec_nxt;
			pos_sel    <= pos_nxt;
			disc_sel   <= disc_nxt;
		end
	end

	// Checks on the answer logic and on the link bit strobe
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_ONE_LEVEL: assert property ($onehot0({seek_ok, busy, seek_err, held_peer}))
		else $error("more than one answer level");
	AST_PARITY_ERR: assert property ((cs_r == CS_IDLE && req_ev && !par_ok && !sel_ev) |=>
		(seek_err && !seek_ok && cs_r == CS_IDLE))
		else $error("bad parity not answered by error");
	AST_WRONG_ERR: assert property (wrg_ev |=> (seek_err && wrong_cmd))
		else $error("early select without error");
	AST_SEL_CLEARS: assert property ((sel_ev && !wrg_ev) |=>
		(!seek_ok && !busy && !seek_err && !held_peer && !settled))
		else $error("select left an answer level");
	AST_CONN_LAST: assert property ((cs_r == CS_IDLE && req_ev) |=> conn_ch == $past(ch_d))
		else $error("not connected to last addressed channel");
	AST_LONG_TIME: assert property ((cs_r == CS_IDLE && req_ev && !sel_ev && !wrg_ev
		&& tmr_nxt == `TMR_W'(`ANS_LONG_CYC - 1)) |=> !seek_ok [*8])
		else $error("long answer came early");
	AST_TIME_DONE: assert property ((cs_r == CS_TIME && tmr_r == '0 && !sel_ev && !wrg_ev)
		|=> (seek_ok && pos_enable[conn_ch]))
		else $error("complete not issued at timer end");
	AST_SETTLE_CONN: assert property ((!settled && !sel_ev && !end_ev && cfmg_r && hdr_s2[conn_ch])
		|=> settled)
		else $error("connected channel settle missed");
	AST_BUSY_HOLD: assert property ((busy && cs_r == CS_BUSYW && cfl_s2[conn_ch]
		&& !sel_ev && !wrg_ev) |=> busy)
		else $error("busy dropped while area held");
	AST_STROBE_SHORT: assert property (@(posedge link_clk) disable iff (lrst_s2)
		bit_strobe |=> !bit_strobe)
		else $error("strobe wider than one cycle");

	COV_ACCEPT: cover property ($rose(seek_ok));
	COV_BUSY_RELEASE: cover property (busy ##1 seek_ok);
	COV_FAST_SETTLE: cover property ($rose(seek_ok) && settled);
	COV_WRONG: cover property ($rose(wrong_cmd));

endmodule : disc_seek_select

//--- disc_host_model.sv
// Host computer model: select pulses and a serial address sent on the bit strobes
`timescale 1ns/1ns
module disc_host_model (
	// Link side
	input  wire logic link_clk,
	input  wire logic bit_strobe,
	output logic      select_in,
	output logic      wdata_in
);
	logic [25:0] addr_r;
	int          nbits;
	int          sent;
	int          idle;
	time         t_sel;
	time         t_first;

	// Lines quiet at time zero
	initial begin
		select_in = 1'h0;
		wdata_in  = 1'h0;
		nbits     = 0;
		sent      = 0;
		idle      = 0;
	end

	// Pulse high four link cycles, then low four so the next one is legal
	task automatic pulse();
		@(posedge link_clk);
		#1 select_in = 1'h1;
		t_sel = $time;
		repeat (4) @(posedge link_clk);
		#1 select_in = 1'h0;
		repeat (4) @(posedge link_clk);
	endtask : pulse

	// Every request is followed by a whole address
	task automatic start(input logic [25:0] a, input int n);
		addr_r  = a;
		nbits   = n;
		sent    = 0;
		t_first = 0;
		pulse();
	endtask : start

	// Bit k goes out just after strobe k, LSB first per field, and stands to the next strobe
	always @(posedge bit_strobe) begin
		#1;
		if (sent == 0)
			t_first = $time;
		wdata_in = (sent < nbits) ? addr_r[sent] : ~wdata_in;
		sent++;
		idle = 0;
	end

	// Released line toggles, so a late sample never matches by luck
	always @(posedge link_clk) begin
		#2;
		if (!bit_strobe && idle > 4)
			wdata_in = ~wdata_in;
		idle++;
	end
endmodule : disc_host_model

//--- testbench.sv
// Self-checking bench for the seek select interface
`timescale 1ns/1ns
`include "disc_seek_params.svh"
module testbench;
	// Clocks, reset, straps, host link
	logic               core_clk, rst, link_clk, wide_chan_cfg, fh_fitted, end_in;
	logic               select_in, wdata_in, bit_strobe, fh_other;
	// Answers and drive side
	logic               seek_ok, busy, seek_err, wrong_cmd, held_peer, settled, ons_bit, fh_sel;
	logic [`NCH-1:0]    area_conflict, peer_attached, pos_power, hdr_settled, ch_clear, pos_enable;
	logic [3:0]         conn_ch;
	logic [`REC_W-1:0]  rec_sel;
	logic [`POS_W-1:0]  pos_sel;
	logic [`DISC_W-1:0] disc_sel;
	logic [25:0]        a;
	int                 mismatches, checked, lat;

	// Core clock 100 MHz; link clock 64 ns with an unrelated phase
	initial core_clk = 1'h0;
	always #5 core_clk = ~core_clk;
	initial begin
		link_clk = 1'h0;
		#13;
		forever #32 link_clk = ~link_clk;
	end

	disc_seek_select i_dut (.core_clk, .rst, .link_clk, .wide_chan_cfg, .fh_fitted, .select_in, .wdata_in,
		.bit_strobe, .end_in, .seek_ok, .busy, .seek_err, .wrong_cmd, .held_peer, .settled, .area_conflict,
		.fh_other, .peer_attached, .pos_power, .hdr_settled, .ch_clear, .pos_enable, .conn_ch, .ons_bit,
		.fh_sel, .rec_sel, .pos_sel, .disc_sel);
	disc_host_model i_host (.link_clk, .bit_strobe, .select_in, .wdata_in);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// Address with odd parity on top; narrow mode keeps the 23 low bits under its own parity
	function automatic logic [25:0] mk(input logic ons, input logic fh, input logic [7:0] rec,
		input logic [5:0] pos, input logic [4:0] disc, input logic [3:0] ch, input logic wide);
		logic [24:0] b;
		b = {ch, disc, pos, rec, fh, ons};
		if (wide)
			return {~^b, b};
		return {2'h0, ~^b[22:0], b[22:0]};
	endfunction : mk

	// Waits out the strobes, then the answer; latency counted from the last strobe
	task automatic await_ans(input logic [3:0] exp, input int lo, input int hi);
		lat = 0;
		while (i_host.sent < i_host.nbits && lat < 20000) begin
			@(negedge core_clk);
			lat++;
		end
		chk(i_host.sent, i_host.nbits);
		chk(i_host.t_first - i_host.t_sel >= 250 && i_host.t_first - i_host.t_sel <= 8000, 1'h1);
		lat = 0;
		do begin
			@(negedge core_clk);
			lat++;
		end while ((seek_ok | busy | seek_err | held_peer) !== 1'h1 && lat < 6000);
		chk({seek_ok, busy, seek_err, held_peer}, exp);
		chk(lat >= lo && lat <= hi, 1'h1);
	endtask : await_ans

	task automatic seek(input logic [25:0] ad, input logic wide, input logic [3:0] exp, input int lo, input int hi);
		i_host.start(ad, wide ? 26 : 24);
		await_ans(exp, lo, hi);
	endtask : seek

	task automatic wait_ok();
		lat = 0;
		while (seek_ok !== 1'h1 && lat < 6000) begin
			@(negedge core_clk);
			lat++;
		end
	endtask : wait_ok

	// Hang guard, about three times the expected run of about 330 us
	initial begin
		#900000;
		mismatches++;
		finish_test();
	end

	// Main sequence; inputs change on falling core edges
	initial begin
		mismatches = 0;
		checked = 0;
		rst = 1'h1;
		wide_chan_cfg = 1'h0;
		fh_fitted = 1'h1;
		end_in = 1'h0;
		fh_other = 1'h0;
		area_conflict = 16'h0000;
		peer_attached = 16'h0000;
		pos_power = 16'hFFFF;
		hdr_settled = 16'h0000;
		ch_clear = 16'h0000;
		// Reset must span several link edges as well as core edges
		repeat (32) @(negedge core_clk);
		chk({seek_ok, busy, seek_err, wrong_cmd, held_peer, settled, pos_enable, conn_ch}, 32'h0);
		rst = 1'h0;
		repeat (5) @(posedge link_clk);
		// Fresh position, power on: long answer and decoded fields
		a = mk(1'h1, 1'h0, 8'h5A, 6'h2C, 5'h13, 4'h1, 1'h0);
		seek(a, 1'h0, 4'h8, 3950, 4300);
		chk({ons_bit, fh_sel, rec_sel, pos_sel, disc_sel, conn_ch}, {1'h1, 1'h0, 8'h5A, 6'h2C, 5'h13, 4'h1});
		chk({pos_enable, settled}, {16'h0002, 1'h0});
		hdr_settled[1] = 1'h1;
		repeat (10) @(negedge core_clk);
		chk(settled, 1'h1);
		end_in = 1'h1;
		repeat (4) @(negedge core_clk);
		end_in = 1'h0;
		repeat (10) @(negedge core_clk);
		chk(settled, 1'h0);
		// Same confirmed target: short answer with settled at once
		seek(a, 1'h0, 4'h8, 1950, 2300);
		chk(settled, 1'h1);
		// Channel clear forgets the confirmed target: long answer, settled not with it
		ch_clear[1] = 1'h1;
		repeat (4) @(negedge core_clk);
		ch_clear[1] = 1'h0;
		repeat (4) @(negedge core_clk);
		chk(pos_enable[1], 1'h0);
		seek(a, 1'h0, 4'h8, 3950, 4300);
		chk(settled, 1'h0);
		// Power off on channel two: short answer, no settled for other channel
		pos_power[2] = 1'h0;
		seek(mk(1'h0, 1'h0, 8'h03, 6'h11, 5'h02, 4'h2, 1'h0), 1'h0, 4'h8, 1950, 2300);
		repeat (20) @(negedge core_clk);
		chk({settled, conn_ch}, {1'h0, 4'h2});
		// Area conflict: busy, positioner waits, confirmation of channel two dropped
		area_conflict[3] = 1'h1;
		seek(mk(1'h0, 1'h0, 8'h10, 6'h05, 5'h07, 4'h3, 1'h0), 1'h0, 4'h4, 0, 100);
		hdr_settled[2] = 1'h1;
		repeat (20) @(negedge core_clk);
		chk({settled, busy, pos_enable[3], conn_ch}, {3'h2, 4'h3});
		area_conflict[3] = 1'h0;
		wait_ok();
		chk({seek_ok, busy, pos_enable[3]}, 3'h5);
		// Bad parity: error and no positioner
		seek(mk(1'h0, 1'h0, 8'h44, 6'h07, 5'h01, 4'h0, 1'h0) ^ 26'h0800000, 1'h0, 4'h2, 0, 100);
		chk(pos_enable[0], 1'h0);
		// Fixed head free: short answer clears the error
		seek(mk(1'h0, 1'h1, 8'h02, 6'h0B, 5'h01, 4'h0, 1'h0), 1'h0, 4'h8, 1950, 2300);
		chk(fh_sel, 1'h1);
		fh_other = 1'h1;
		seek(mk(1'h0, 1'h1, 8'h01, 6'h03, 5'h00, 4'h1, 1'h0), 1'h0, 4'h4, 0, 100);
		// Fixed head above eleven: error, and the busy level is cleared
		seek(mk(1'h0, 1'h1, 8'h01, 6'h0C, 5'h00, 4'h1, 1'h0), 1'h0, 4'h2, 0, 100);
		fh_other = 1'h0;
		// Second select in mid-address: flagged fast, first request still answered
		i_host.start(mk(1'h0, 1'h0, 8'h01, 6'h21, 5'h01, 4'h0, 1'h0), 24);
		repeat (20) @(posedge link_clk);
		i_host.pulse();
		chk({wrong_cmd, seek_err}, 2'h3);
		wait_ok();
		chk({seek_ok, seek_err}, 2'h2);
		// No fixed-head field fitted: 23 bits, record follows the sector bit
		fh_fitted = 1'h0;
		a = mk(1'h1, 1'h0, 8'hC3, 6'h15, 5'h0A, 4'h2, 1'h0);
		i_host.start({3'h0, a[23:2], a[0]}, 23);
		await_ans(4'h8, 1950, 2300);
		chk({ons_bit, fh_sel, rec_sel, pos_sel, disc_sel, conn_ch}, {1'h1, 1'h0, 8'hC3, 6'h15, 5'h0A, 4'h2});
		fh_fitted = 1'h1;
		// Wide field: channel owned by the peer, then an ordinary wide seek
		@(negedge core_clk);
		wide_chan_cfg = 1'h1;
		peer_attached[9] = 1'h1;
		seek(mk(1'h0, 1'h0, 8'h22, 6'h33, 5'h04, 4'h9, 1'h1), 1'h1, 4'h1, 0, 100);
		seek(mk(1'h0, 1'h0, 8'h66, 6'h12, 5'h1F, 4'hE, 1'h1), 1'h1, 4'h8, 3950, 4300);
		chk({conn_ch, pos_enable[14]}, 5'h1D);
		finish_test();
	end
endmodule : testbench
